// [design/flash_reset_sr_core.sv]
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "flash_dw16_defs.svh"

module flash_reset_sr_core
  import flash_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic chipSelect_b,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck
);
  pin_if link ();

  pin_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .sclkPin(sclk),
    .csPin_b(chipSelect_b),
    .ioPin(ioIn),
    .link(link)
  );

  phase_t phase;
  lineMode_t lineMode;
  path_t path;
  readKind_t kind;
  logic quadFrame, armed, pendReset, softReset, cont, exitCont, srByteDone;
  logic [5:0] bitCnt, next_bitCnt;
  logic [31:0] shiftIn, next_shift, statusWord;
  logic [23:0] addr;
  logic [7:0] srData, volSr1, outShift, lastByte, opByte, srView, loadByte, sendByte;
  // Stands in for the array cell: kept across rst_b, set only at power-up and by a status write on PATH_NV
  logic [7:0] nvSr1 = `SR1_NV_INIT;
  logic [3:0] outLeft;
  logic [2:0] curW;
  logic opDone, modeDone, srWrite, outActive, wbReq;

  function automatic logic [2:0] laneCount(input lineMode_t m);
    case (m)
      LM_DUAL: laneCount = 3'h2;
      LM_QUAD: laneCount = 3'h4;
      default: laneCount = 3'h1;
    endcase
  endfunction

  function automatic logic [31:0] takeBits(input logic [31:0] s, input logic [3:0] d, input logic [2:0] w);
    case (w)
      3'h4: takeBits = {s[27:0], d};
      3'h2: takeBits = {s[29:0], d[1:0]};
      default: takeBits = {s[30:0], d[0]};
    endcase
  endfunction

  // Single-line output goes out on io1, the classic data-out pin
  function automatic logic [3:0] driveLanes(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'h4: driveLanes = b[7:4];
      3'h2: driveLanes = {2'h0, b[7:6]};
      default: driveLanes = {2'h0, b[7], 1'h0};
    endcase
  endfunction

  function automatic logic [3:0] laneMask(input logic [2:0] w);
    case (w)
      3'h4: laneMask = 4'hF;
      3'h2: laneMask = 4'h3;
      default: laneMask = 4'h2;
    endcase
  endfunction

  function automatic logic [7:0] sfdpByte(input logic [23:0] a);
    logic [31:0] dw;
    dw = `SFDP_DW16;
    if ((a & 24'hFF_FFFC) != `SFDP_DW16_ADDR) begin
      sfdpByte = `SFDP_BLANK;
    end else begin
      case (a[1:0])
        2'h0: sfdpByte = dw[7:0];
        2'h1: sfdpByte = dw[15:8];
        2'h2: sfdpByte = dw[23:16];
        default: sfdpByte = dw[31:24];
      endcase
    end
  endfunction

  always_comb begin
    curW = quadFrame ? 3'h4 : laneCount(lineMode);
    next_bitCnt = bitCnt + ((phase == PH_DUMMY) ? 6'h01 : {3'h0, curW});
    next_shift = takeBits(shiftIn, link.io, curW);
    opByte = next_shift[7:0];
    opDone = link.sclkRise && link.csLow && phase == PH_OPCODE && next_bitCnt == `OPCODE_BITS;
    modeDone = link.sclkRise && link.csLow && phase == PH_MODE && next_bitCnt == `MODE_BITS;
    srWrite = link.csRise && srByteDone && path != PATH_NONE;
    outActive = link.csLow && phase == PH_DATA && kind != RK_SRW && kind != RK_NONE;
    srView = (volSr1 & `SR1_STORED_MASK) | {6'h00, path != PATH_NONE, 1'h0};
    case (kind)
      RK_SR: loadByte = srView;
      RK_SFDP: loadByte = sfdpByte(addr);
      default: loadByte = `ARRAY_BLANK;
    endcase
    sendByte = (outLeft == 4'h0) ? loadByte : outShift;
    wbReq = wbCyc && wbStb && !wbAck;
    statusWord = 32'h0000_0000;
    statusWord[`STAT_ARMED] = armed;
    statusWord[`STAT_PEND] = pendReset;
    statusWord[`STAT_CONT] = cont;
    statusWord[`STAT_PATH_HI:`STAT_PATH_LO] = path;
    statusWord[`STAT_MODE_HI:`STAT_MODE_LO] = lineMode;
  end

  // Frame sequencing: opcode, address, mode, dummy and data phases
  always_ff @(posedge clk) begin
    if (!rst_b || softReset) begin
      phase <= PH_IDLE;
      kind <= RK_NONE;
      quadFrame <= 1'h0;
      bitCnt <= 6'h00;
      shiftIn <= 32'h0000_0000;
      addr <= 24'h00_0000;
      srData <= 8'h00;
      srByteDone <= 1'h0;
    end else if (link.csRise) begin
      phase <= PH_IDLE;
      srByteDone <= 1'h0;
    end else if (link.csFall) begin
      bitCnt <= 6'h00;
      shiftIn <= 32'h0000_0000;
      quadFrame <= cont;
      phase <= cont ? PH_ADDR : PH_OPCODE;
      kind <= cont ? RK_QUAD : RK_NONE;
    end else if (link.sclkRise && link.csLow && phase != PH_IDLE) begin
      shiftIn <= next_shift;
      bitCnt <= next_bitCnt;
      case (phase)
        PH_OPCODE: begin
          if (opDone) begin
            bitCnt <= 6'h00;
            case (opByte)
              `OP_READ_SFDP: begin
                kind <= RK_SFDP;
                phase <= PH_ADDR;
              end
              `OP_QUAD_READ: begin
                kind <= RK_QUAD;
                quadFrame <= 1'h1;
                phase <= PH_ADDR;
              end
              `OP_READ_SR1: begin
                kind <= RK_SR;
                phase <= PH_DATA;
              end
              `OP_WRITE_SR1: begin
                kind <= RK_SRW;
                phase <= PH_DATA;
              end
              default: phase <= PH_IDLE;
            endcase
          end
        end
        PH_ADDR: begin
          if (next_bitCnt == `ADDR_BITS) begin
            addr <= next_shift[23:0];
            bitCnt <= 6'h00;
            phase <= (kind == RK_QUAD) ? PH_MODE : PH_DUMMY;
          end
        end
        PH_MODE: begin
          if (modeDone) begin
            bitCnt <= 6'h00;
            phase <= (next_shift == `CONT_ESCAPE) ? PH_IDLE : PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          if (next_bitCnt == ((kind == RK_QUAD) ? `QUAD_DUMMY_CLKS : `SFDP_DUMMY_CLKS)) begin
            bitCnt <= 6'h00;
            phase <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (kind != RK_SRW) begin
            bitCnt <= 6'h00;
          end else if (next_bitCnt == `DATA_BITS) begin
            // Only the first data byte counts; later bytes are dropped
            srData <= next_shift[7:0];
            srByteDone <= 1'h1;
            phase <= PH_IDLE;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end else if (link.sclkFall && outActive && outLeft == 4'h0 && kind == RK_SFDP) begin
      addr <= addr + 24'h00_0001;
    end
  end

  // Reset pair: any opcode rewrites the arm, so only 66h directly before 99h counts
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      armed <= 1'h0;
      pendReset <= 1'h0;
      softReset <= 1'h0;
    end else begin
      softReset <= 1'h0;
      if (opDone) begin
        armed <= (opByte == `OP_RST_EN);
        pendReset <= (opByte == `OP_RST) && armed;
      end else if (link.csRise && pendReset) begin
        // Reset waits for deselect so the frame closes cleanly
        softReset <= 1'h1;
        pendReset <= 1'h0;
        armed <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || softReset) begin
      path <= PATH_NONE;
      volSr1 <= nvSr1 & `SR1_STORED_MASK;
    end else if (opDone && opByte == `OP_WREN) begin
      path <= PATH_NV;
    end else if (opDone && opByte == `OP_VOL_WREN) begin
      path <= PATH_VOL;
    end else if (srWrite) begin
      path <= PATH_NONE;
      volSr1 <= srData & `SR1_STORED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srWrite && path == PATH_NV) begin
      nvSr1 <= srData & `SR1_STORED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || softReset) begin
      cont <= 1'h0;
      exitCont <= 1'h0;
    end else if (modeDone && opByte == `MODE_CONT_ENTER) begin
      cont <= 1'h1;
    end else if (modeDone && opByte == `MODE_CONT_EXIT) begin
      exitCont <= 1'h1;
    end else if (modeDone && next_shift == `CONT_ESCAPE) begin
      cont <= 1'h0;
    end else if (link.csRise && exitCont) begin
      cont <= 1'h0;
      exitCont <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || softReset) begin
      lineMode <= LM_SPI;
    end else if (opDone && opByte == `OP_QPI_ON) begin
      lineMode <= LM_QUAD;
    end else if (opDone && opByte == `OP_QPI_OFF && lineMode == LM_QUAD) begin
      lineMode <= LM_SPI;
    end else if (wbReq && wbWe && wbSel[0] && wbAdr == `REG_CTRL && wbDatI[1:0] != 2'h3) begin
      lineMode <= lineMode_t'(wbDatI[1:0]);
    end
  end

  // Output lanes change on the falling edge so the host samples a settled bit
  always_ff @(posedge clk) begin
    if (!rst_b || !link.csLow) begin
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      outShift <= 8'h00;
      outLeft <= 4'h0;
      lastByte <= 8'h00;
    end else if (link.sclkFall && outActive) begin
      ioOut <= driveLanes(sendByte, curW);
      ioOe <= laneMask(curW);
      outShift <= sendByte << curW;
      outLeft <= ((outLeft == 4'h0) ? 4'h8 : outLeft) - {1'h0, curW};
      if (outLeft == 4'h0) begin
        lastByte <= loadByte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wbAck <= 1'h0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAck <= wbReq;
      if (wbReq) begin
        case (wbAdr)
          `REG_CTRL: wbDatO <= {30'h0000_0000, lineMode};
          `REG_STATUS: wbDatO <= statusWord;
          `REG_SR1: wbDatO <= {16'h0000, nvSr1, srView};
          default: wbDatO <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_sfdp_byte_6c: assert property (@(posedge clk) disable iff (!rst_b)
    (link.sclkFall && outActive && outLeft == 4'h0 && kind == RK_SFDP && addr == 24'h00_006C)
    |=> (lastByte == 8'hE8)) else $error("byte 6Ch not E8h");
  a_sfdp_byte_6d: assert property (@(posedge clk) disable iff (!rst_b)
    (link.sclkFall && outActive && outLeft == 4'h0 && kind == RK_SFDP && addr == 24'h00_006D)
    |=> (lastByte == 8'h30)) else $error("byte 6Dh not 30h");
  a_sfdp_byte_6e: assert property (@(posedge clk) disable iff (!rst_b)
    (link.sclkFall && outActive && outLeft == 4'h0 && kind == RK_SFDP && addr == 24'h00_006E)
    |=> (lastByte == 8'hC0)) else $error("byte 6Eh not C0h");
  a_sfdp_byte_6f: assert property (@(posedge clk) disable iff (!rst_b)
    (link.sclkFall && outActive && outLeft == 4'h0 && kind == RK_SFDP && addr == 24'h00_006F)
    |=> (lastByte == 8'h80)) else $error("byte 6Fh not 80h");
  a_reset_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (opDone && opByte == 8'h99 && !armed) |=> !pendReset ##1 !softReset) else $error("reset without enable");
  a_reset_state: assert property (@(posedge clk) disable iff (!rst_b)
    (link.csRise && pendReset) |=> softReset ##1 (lineMode == LM_SPI && !cont && path == PATH_NONE))
    else $error("soft reset not taken");
  a_power_sr1: assert property (@(posedge clk) disable iff (!rst_b)
    softReset |=> (volSr1 == ($past(nvSr1) & 8'hFC))) else $error("status not reloaded");
  a_nv_write: assert property (@(posedge clk) disable iff (!rst_b)
    (srWrite && path == PATH_NV) |=> (nvSr1 == ($past(srData) & 8'hFC) && volSr1 == nvSr1))
    else $error("non-volatile write lost");
  a_vol_write: assert property (@(posedge clk) disable iff (!rst_b)
    (srWrite && path == PATH_VOL) |=> (nvSr1 == $past(nvSr1) && volSr1 == ($past(srData) & 8'hFC)))
    else $error("volatile write wrong");
  a_path_once: assert property (@(posedge clk) disable iff (!rst_b)
    srWrite |=> (path == PATH_NONE) [*2]) else $error("write path not cleared");
  a_cont_exit: assert property (@(posedge clk) disable iff (!rst_b)
    (modeDone && cont && opByte == 8'h00) |=> exitCont until_with (link.csRise || softReset))
    else $error("exit request dropped");
  a_cont_close: assert property (@(posedge clk) disable iff (!rst_b)
    (link.csRise && exitCont) |=> !cont) else $error("continuous read not ended");
  a_quad_width: assert property (@(posedge clk) disable iff (!rst_b)
    (link.sclkRise && link.csLow && phase == PH_OPCODE && lineMode == LM_QUAD && bitCnt == 6'h00)
    |=> (bitCnt == 6'h04)) else $error("quad opcode width wrong");
  a_wb_answer: assert property (@(posedge clk) disable iff (!rst_b)
    wbReq |=> wbAck ##1 !wbAck) else $error("bus ack wrong");
endmodule

// [design/flash_dw16_defs.svh]
`ifndef FLASH_DW16_DEFS_SVH
`define FLASH_DW16_DEFS_SVH

`define DW16_ENTER4B 8'h80
`define DW16_EXIT4B 10'h300
`define DW16_SOFTRST 6'h30
`define DW16_RFU7 1'h1
`define DW16_SR1_VOL 7'h68
`define SFDP_DW16 {`DW16_ENTER4B, `DW16_EXIT4B, `DW16_SOFTRST, `DW16_RFU7, `DW16_SR1_VOL}
`define SFDP_DW16_ADDR 24'h00_006C
`define SFDP_BLANK 8'hFF
`define ARRAY_BLANK 8'hFF

`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_WREN 8'h06
`define OP_VOL_WREN 8'h50
`define OP_WRITE_SR1 8'h01
`define OP_READ_SR1 8'h05
`define OP_READ_SFDP 8'h5A
`define OP_QUAD_READ 8'hEB
`define OP_QPI_ON 8'h38
`define OP_QPI_OFF 8'hFF
`define MODE_CONT_ENTER 8'hA5
`define MODE_CONT_EXIT 8'h00
`define CONT_ESCAPE 32'hFFFF_FFFF

`define OPCODE_BITS 6'h08
`define ADDR_BITS 6'h18
`define MODE_BITS 6'h08
`define DATA_BITS 6'h08
`define SFDP_DUMMY_CLKS 6'h08
`define QUAD_DUMMY_CLKS 6'h04

`define SR1_NV_INIT 8'h00
`define SR1_STORED_MASK 8'hFC
`define PIN_IDLE 6'h10

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SR1 8'h08
`define STAT_ARMED 0
`define STAT_PEND 1
`define STAT_CONT 2
`define STAT_PATH_LO 3
`define STAT_PATH_HI 4
`define STAT_MODE_LO 5
`define STAT_MODE_HI 6
`endif

// [design/flash_pkg.sv]
package flash_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_OPCODE = 3'h1,
    PH_ADDR = 3'h3,
    PH_MODE = 3'h2,
    PH_DUMMY = 3'h6,
    PH_DATA = 3'h7
  } phase_t;
  typedef enum logic [1:0] {LM_SPI = 2'h0, LM_DUAL = 2'h1, LM_QUAD = 2'h2} lineMode_t;
  typedef enum logic [1:0] {PATH_NONE = 2'h0, PATH_NV = 2'h1, PATH_VOL = 2'h2} path_t;
  typedef enum logic [2:0] {RK_NONE = 3'h0, RK_SR = 3'h1, RK_SFDP = 3'h2, RK_QUAD = 3'h3, RK_SRW = 3'h4} readKind_t;
endpackage

// [design/pin_if.sv]
`timescale 1ns/10ps
interface pin_if;
  logic sclkRise;
  logic sclkFall;
  logic csFall;
  logic csRise;
  logic csLow;
  logic [3:0] io;
  modport source (output sclkRise, output sclkFall, output csFall, output csRise, output csLow, output io);
  modport sink (input sclkRise, input sclkFall, input csFall, input csRise, input csLow, input io);
endinterface

// [design/pin_sync.sv]
`timescale 1ns/10ps
`include "flash_dw16_defs.svh"

module pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclkPin,
  input wire logic csPin_b,
  input wire logic [3:0] ioPin,
  pin_if.source link
);
  logic [5:0] s1, s2, s3, level, agree, next_level;

  // A level moves only once stages two and three agree
  assign agree = s2 ~^ s3;
  assign next_level = (level & ~agree) | (s3 & agree);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1 <= `PIN_IDLE;
      s2 <= `PIN_IDLE;
      s3 <= `PIN_IDLE;
    end else begin
      s1 <= {sclkPin, csPin_b, ioPin};
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level <= `PIN_IDLE;
      link.sclkRise <= 1'h0;
      link.sclkFall <= 1'h0;
      link.csFall <= 1'h0;
      link.csRise <= 1'h0;
      link.csLow <= 1'h0;
      link.io <= 4'h0;
    end else begin
      level <= next_level;
      link.sclkRise <= next_level[5] & ~level[5];
      link.sclkFall <= ~next_level[5] & level[5];
      link.csFall <= ~next_level[4] & level[4];
      link.csRise <= next_level[4] & ~level[4];
      link.csLow <= ~next_level[4];
      link.io <= next_level[3:0];
    end
  end
endmodule

// [test/spi_host_model.sv]
`timescale 1ns/10ps

module spi_host_model (
  input wire logic clk,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  output logic sclk,
  output logic csPin_b,
  output logic [3:0] ioIn
);
  logic [3:0] hostVal = 4'h0;
  logic [3:0] hostEn = 4'h0;
  logic [3:0] noise = 4'h5;

  initial begin
    sclk = 1'b0;
    csPin_b = 1'b1;
  end

  // Released lines toggle so a stale level never passes for read data
  always @(posedge clk) begin
    noise <= ~noise;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ioIn[i] = ioOe[i] ? ioOut[i] : (hostEn[i] ? hostVal[i] : noise[i]);
    end
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start();
    csPin_b <= 1'b0;
    ticks(4);
  endtask

  // Clock parks low before the frame closes
  task automatic stop();
    sclk <= 1'b0;
    hostEn <= 4'h0;
    ticks(4);
    csPin_b <= 1'b1;
    ticks(8);
  endtask

  task automatic send(input logic [31:0] data, input int nBits, input int width);
    for (int b = nBits - width; b >= 0; b -= width) begin
      sclk <= 1'b0;
      hostEn <= 4'((5'h01 << width) - 5'h01);
      hostVal <= 4'(data >> b);
      ticks(4);
      sclk <= 1'b1;
      ticks(4);
    end
  endtask

  // Sampled late in the high phase, well after the device's output lag
  task automatic recv(input int nUnits, input int width, output logic [63:0] rd);
    rd = '0;
    for (int u = 0; u < nUnits; u++) begin
      sclk <= 1'b0;
      hostEn <= 4'h0;
      ticks(4);
      sclk <= 1'b1;
      ticks(4);
      rd = (rd << width) | 64'(width == 1 ? {3'h0, ioIn[1]} : ioIn & 4'((5'h01 << width) - 5'h01));
    end
  endtask

  task automatic frame(input logic [7:0] code, input int width);
    start();
    send(32'(code), 8, width);
    stop();
  endtask

  task automatic escape();
    start();
    send(32'hFFFF_FFFF, 32, 4);
    stop();
  endtask
endmodule

// [test/tb_flash_reset_sr_core.sv]
`timescale 1ns/10ps
`include "flash_dw16_defs.svh"

module tb_flash_reset_sr_core;
  logic clk = 1'b0;
  logic rst_b;
  logic sclk;
  logic csPin_b;
  logic [3:0] ioIn;
  logic [3:0] ioOut;
  logic [3:0] ioOe;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [63:0] pin;
  logic [31:0] dw;
  int badCount = 0;
  int checkCount = 0;

  always #25 clk = ~clk;

  flash_reset_sr_core u_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .chipSelect_b(csPin_b), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck));

  spi_host_model u_host (.clk(clk), .ioOut(ioOut), .ioOe(ioOe), .sclk(sclk), .csPin_b(csPin_b), .ioIn(ioIn));

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chkBus(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic [63:0] got, input logic [63:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    wbSel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      badCount++;
      closeOut();
    end
  endtask

  task automatic wrReg(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    wbXfer(1'b1, adr, dat, unused);
  endtask

  task automatic expReg(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    wbXfer(1'b0, adr, 32'h0000_0000, got);
    chkBus(got, exp);
  endtask

  task automatic wrSr(input logic [7:0] val);
    u_host.start();
    u_host.send({16'h0000, `OP_WRITE_SR1, val}, 16, 1);
    u_host.stop();
  endtask

  // Address 10h is blank, so every data nibble must be ones
  task automatic quadRead(input logic withOp, input logic [7:0] modeBits);
    u_host.start();
    if (withOp) begin
      u_host.send(32'(`OP_QUAD_READ), 8, 1);
    end
    u_host.send({24'h00_0010, modeBits}, 32, 4);
    u_host.recv(4, 4, pin);
    u_host.recv(2, 4, pin);
    u_host.stop();
    chkPin(pin, 64'h0000_0000_0000_00FF);
  endtask

  initial begin
    rst_b = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    expReg(`REG_STATUS, 32'h0000_0000);
    expReg(`REG_SR1, 32'h0000_0000);
    expReg(8'h0C, 32'h0000_0000);
    // Straddle the doubleword so both neighbours prove its edges
    u_host.start();
    u_host.send({`OP_READ_SFDP, 24'h00_006B}, 32, 1);
    u_host.recv(8, 1, pin);
    u_host.recv(48, 1, pin);
    u_host.stop();
    chkPin(pin, 64'h0000_FFE8_30C0_80FF);
    dw = {pin[15:8], pin[23:16], pin[31:24], pin[39:32]};
    chkBus(32'(dw[31:24]), 32'h0000_0080);
    chkBus(32'(dw[23:14]), 32'h0000_0300);
    chkBus(32'(dw[13:7]), 32'h0000_0061);
    chkBus(32'(dw[6:0]), 32'h0000_0068);
    u_host.frame(`OP_WREN, 1);
    expReg(`REG_STATUS, 32'h0000_0008);
    u_host.frame(`OP_RST_EN, 1);
    expReg(`REG_STATUS, 32'h0000_0009);
    u_host.frame(`OP_READ_SR1, 1);
    u_host.frame(`OP_RST, 1);
    expReg(`REG_STATUS, 32'h0000_0008);
    for (int m = 0; m < 3; m++) begin
      wrReg(`REG_CTRL, 32'(m));
      u_host.frame(`OP_WREN, 1 << m);
      expReg(`REG_STATUS, 32'((m << 5) | 8));
      u_host.frame(`OP_RST_EN, 1 << m);
      u_host.frame(`OP_RST, 1 << m);
      expReg(`REG_STATUS, 32'h0000_0000);
    end
    u_host.frame(`OP_WREN, 1);
    wrSr(8'hA7);
    expReg(`REG_SR1, 32'h0000_A4A4);
    expReg(`REG_STATUS, 32'h0000_0000);
    u_host.frame(`OP_VOL_WREN, 1);
    expReg(`REG_STATUS, 32'h0000_0010);
    wrSr(8'h5B);
    expReg(`REG_SR1, 32'h0000_A458);
    wrSr(8'hFF);
    expReg(`REG_SR1, 32'h0000_A458);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    expReg(`REG_SR1, 32'h0000_A4A4);
    quadRead(1'b1, `MODE_CONT_ENTER);
    expReg(`REG_STATUS, 32'h0000_0004);
    quadRead(1'b0, `MODE_CONT_EXIT);
    expReg(`REG_STATUS, 32'h0000_0000);
    quadRead(1'b1, `MODE_CONT_ENTER);
    u_host.escape();
    expReg(`REG_STATUS, 32'h0000_0000);
    u_host.frame(`OP_WREN, 1);
    u_host.frame(`OP_RST_EN, 1);
    u_host.frame(`OP_RST, 1);
    expReg(`REG_STATUS, 32'h0000_0000);
    closeOut();
  end
endmodule
